// ### core/host_cmd_pkg.sv
/*
  Shared constants and types of the host command interface register block:
  register offsets, status and command bit positions, reset values, the
  buffer size offered by the module and the negotiation phase type.
  Assumes a single clock domain and a byte-wide host port with two address lines.
*/
// Summary of operation
// - Offset 0 moves data bytes both ways
// - Offset 1: reads flags, writes command
// - Sixteen-bit count, low byte 2, high 3
// - Only two address lines are decoded
// - Bit 7 high while outgoing data waits
// - Bit 6 high when free or reset done
// - Bit 1 write error, 0 read error
// - Command bits: reset, size read/write, control
// - Reset command clears only this interface
// - Reset flushes, awaits negotiation, raises free
// - No payload before size negotiation ends
// - Size read: two bytes, high first
// - Offered buffer size between 16 and 65535
// - Size write: two bytes, high first
// - One negotiated size for both directions; code bounds only outgoing counts by it, host write counts are not checked
// - First written byte: error set, free cleared
// - Write error clears at last, resets after
// - Read error and pending flag mirror writes
// - Count bytes accessible in either order
package host_cmd_pkg;

  // Register offsets inside the four-byte window
  localparam logic [1:0] OFS_TRANSFER_DATA = 2'h0;
  localparam logic [1:0] OFS_INTERFACE_FLAGS = 2'h1;
  localparam logic [1:0] OFS_INTERFACE_COMMAND = 2'h1;
  localparam logic [1:0] OFS_COUNT_LOW = 2'h2;
  localparam logic [1:0] OFS_COUNT_HIGH = 2'h3;

  // Status bit positions
  localparam int FLAG_PENDING_BIT = 7;
  localparam int FLAG_FREE_BIT = 6;
  localparam int FLAG_WRITE_ERR_BIT = 1;
  localparam int FLAG_READ_ERR_BIT = 0;

  // Command bit positions
  localparam int CMD_RESET_BIT = 3;
  localparam int CMD_SIZE_READ_BIT = 2;
  localparam int CMD_SIZE_WRITE_BIT = 1;
  localparam int CMD_HOST_CTRL_BIT = 0;

  // Reserved status bits read as zero
  localparam logic [3:0] FLAG_RESERVED_VALUE = 4'h0;

  // Buffer size offered during size read, at least 16 bytes
  localparam logic [15:0] MODULE_BUF_SIZE = 16'h0400;
  localparam logic [15:0] MODULE_BUF_MIN = 16'h0010;
  // Bytes in a size read or size write transfer
  localparam logic [15:0] SIZE_XFER_LEN = 16'h0002;

  // Reset values
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] NEG_SIZE_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_ONE = 16'h0001;

  // Negotiation phase of the interface
  typedef enum logic [1:0] {
    PH_AWAIT_SIZE_READ = 2'b00,
    PH_SIZE_READ = 2'b01,
    PH_AWAIT_SIZE_WRITE = 2'b10,
    PH_READY = 2'b11
  } phase_type;

endpackage

// ### core/length_tracker.sv
/*
  Counts bytes of one transfer direction against the announced count and
  keeps the length error flag of that direction.
  Assumes byte_pulse and restart are one-cycle pulses in the clk_sys domain.
*/
`timescale 1ns/1ps
`default_nettype none
module length_tracker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Control
  input wire logic restart,
  input wire logic byte_pulse,
  input wire logic [15:0] total,
  // Results
  output logic last_pulse,
  output logic length_err
);

  // All state of the tracker
  typedef struct packed {
    logic [15:0] count;
    logic err;
  } tracker_type;

  tracker_type state_reg;
  tracker_type state_next;
  logic [15:0] count_inc; // Count after this byte

  // Next count, error and completion
  always_comb begin
    state_next = state_reg;
    count_inc = (state_reg.count == host_cmd_pkg::COUNT_MAX) ? state_reg.count :
                state_reg.count + host_cmd_pkg::COUNT_ONE;
    last_pulse = 1'b0;
    if (restart) begin
      // New transfer announced
      state_next.count = host_cmd_pkg::COUNT_RESET;
      state_next.err = 1'b0;
    end else if (byte_pulse) begin
      state_next.count = count_inc;
      // Error from first byte until the last, again on any extra one
      state_next.err = (count_inc != total);
      last_pulse = (count_inc == total);
    end
  end

  // Register the state
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign length_err = state_reg.err;

endmodule
`default_nettype wire

// ### core/reg_window_decode.sv
/*
  Decodes the two host address lines into per-register strobes and returns
  the read byte one cycle after the read strobe, with its output enable.
  Assumes host strobes are one-cycle pulses synchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module reg_window_decode (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Host access
  input wire logic [1:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  // Values to return
  input wire logic [7:0] data_value,
  input wire logic [7:0] flags_value,
  input wire logic [15:0] count_value,
  // Strobes per offset
  output logic [3:0] wr_sel,
  output logic [3:0] rd_sel,
  // Read data pins
  output logic [7:0] rd_byte,
  output logic rd_oe
);

  // All state of the decoder
  typedef struct packed {
    logic [7:0] rdata;
    logic oe;
  } decode_type;

  decode_type state_reg;
  decode_type state_next;

  // One strobe per offset, only address lines 0 and 1 take part
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_sel
      assign wr_sel[i] = host_wr && (host_addr == 2'(i));
      assign rd_sel[i] = host_rd && (host_addr == 2'(i));
    end
  endgenerate

  // Read multiplexer
  always_comb begin
    state_next = state_reg;
    state_next.oe = host_rd;
    if (host_rd) begin
      unique case (host_addr)
        host_cmd_pkg::OFS_TRANSFER_DATA: state_next.rdata = data_value;
        host_cmd_pkg::OFS_INTERFACE_FLAGS: state_next.rdata = flags_value;
        host_cmd_pkg::OFS_COUNT_LOW: state_next.rdata = count_value[7:0];
        host_cmd_pkg::OFS_COUNT_HIGH: state_next.rdata = count_value[15:8];
      endcase
    end
  end

  // Register the state
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_byte = state_reg.rdata;
  assign rd_oe = state_reg.oe;

endmodule
`default_nettype wire

// ### core/host_command_interface.sv
/*
  Command interface register block of the module: data, flags/command and
  byte count registers seen by the host, buffer size negotiation, and the
  write and read handshakes with their length error flags.
  Assumes host strobes are one-cycle pulses synchronous to clk_sys, and that
  the module side feeds outgoing bytes through a one-byte staging register.
*/
`timescale 1ns/1ps
`default_nettype none
module host_command_interface (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Host register port
  input wire logic [1:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  output logic [7:0] host_rdata,
  output logic host_data_oe,
  // Incoming bytes to the module side
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic rx_last,
  // Outgoing transfer from the module side
  input wire logic tx_start,
  input wire logic [15:0] tx_count,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // Interface status to the module side
  output logic iface_flush,
  output logic size_negotiated,
  output logic [15:0] negotiated_size
);

  // All state of the interface
  typedef struct packed {
    host_cmd_pkg::phase_type phase;
    logic size_read_request;
    logic size_write_request;
    logic host_control_flag;
    logic outgoing_pending_flag;
    logic free_to_accept_flag;
    logic out_active;
    logic [15:0] byte_count;
    logic [15:0] neg_size;
    logic neg_done;
    logic size_byte_sel;
    logic [7:0] stage_byte;
    logic stage_full;
    logic tx_ready;
    logic [7:0] rx_byte;
    logic rx_valid;
    logic rx_last;
    logic flush;
  } iface_type;

  iface_type state_reg;
  iface_type state_next;

  // Decoded strobes
  logic [3:0] wr_sel;
  logic [3:0] rd_sel;
  logic wr_data;
  logic wr_cmd;
  logic rd_data;
  logic soft_reset;
  // Flags byte and data byte offered to the host
  logic [7:0] flags_value;
  // Length trackers
  logic wr_restart;
  logic wr_byte;
  logic wr_last;
  logic write_length_error;
  logic rd_restart;
  logic rd_byte;
  logic rd_last;
  logic read_length_error;
  logic tx_accept;

  assign wr_data = wr_sel[host_cmd_pkg::OFS_TRANSFER_DATA];
  assign wr_cmd = wr_sel[host_cmd_pkg::OFS_INTERFACE_COMMAND];
  assign rd_data = rd_sel[host_cmd_pkg::OFS_TRANSFER_DATA];
  // Reset command touches only this interface, not the rest of the module
  assign soft_reset = wr_cmd && host_wdata[host_cmd_pkg::CMD_RESET_BIT];

  // Flags byte: reserved bits read as zero
  always_comb begin
    flags_value = 8'h00;
    flags_value[host_cmd_pkg::FLAG_PENDING_BIT] = state_reg.outgoing_pending_flag;
    flags_value[host_cmd_pkg::FLAG_FREE_BIT] = state_reg.free_to_accept_flag;
    flags_value[5:2] = host_cmd_pkg::FLAG_RESERVED_VALUE;
    flags_value[host_cmd_pkg::FLAG_WRITE_ERR_BIT] = write_length_error;
    flags_value[host_cmd_pkg::FLAG_READ_ERR_BIT] = read_length_error;
  end

  // Register window decode and read data
  reg_window_decode u_decode (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .host_addr(host_addr),
    .host_wr(host_wr),
    .host_rd(host_rd),
    .data_value(state_reg.stage_byte),
    .flags_value(flags_value),
    .count_value(state_reg.byte_count),
    .wr_sel(wr_sel),
    .rd_sel(rd_sel),
    .rd_byte(host_rdata),
    .rd_oe(host_data_oe)
  );

  // Host writes are counted only while a write may legally run
  assign wr_byte = wr_data && !soft_reset &&
                   ((state_reg.phase == host_cmd_pkg::PH_AWAIT_SIZE_WRITE) ||
                    (state_reg.phase == host_cmd_pkg::PH_READY && state_reg.host_control_flag));
  // Host reads counted in size read and after negotiation; extra ones flag an error
  assign rd_byte = rd_data && !soft_reset &&
                   ((state_reg.phase == host_cmd_pkg::PH_SIZE_READ) ||
                    (state_reg.phase == host_cmd_pkg::PH_READY));
  // Any count write announces a new host transfer
  assign wr_restart = soft_reset || wr_sel[host_cmd_pkg::OFS_COUNT_LOW] ||
                      wr_sel[host_cmd_pkg::OFS_COUNT_HIGH];
  // Outgoing transfer accepted only after negotiation, within the size
  assign tx_accept = tx_start && state_reg.phase == host_cmd_pkg::PH_READY &&
                     !state_reg.out_active && tx_count != host_cmd_pkg::COUNT_RESET &&
                     tx_count <= state_reg.neg_size;
  assign rd_restart = soft_reset ||
                      (state_reg.phase == host_cmd_pkg::PH_AWAIT_SIZE_READ &&
                       state_reg.size_read_request) || tx_accept;

  // Write direction length tracking
  length_tracker u_write_len (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .restart(wr_restart),
    .byte_pulse(wr_byte),
    .total(state_reg.byte_count),
    .last_pulse(wr_last),
    .length_err(write_length_error)
  );

  // Read direction length tracking
  length_tracker u_read_len (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .restart(rd_restart),
    .byte_pulse(rd_byte),
    .total(state_reg.byte_count),
    .last_pulse(rd_last),
    .length_err(read_length_error)
  );

  // Next state of the interface
  always_comb begin
    state_next = state_reg;
    state_next.rx_valid = 1'b0;
    state_next.rx_last = 1'b0;
    state_next.flush = 1'b0;
    if (soft_reset) begin
      // Flush everything and wait for size negotiation again
      state_next = '0;
      state_next.phase = host_cmd_pkg::PH_AWAIT_SIZE_READ;
      state_next.free_to_accept_flag = 1'b1;
      state_next.neg_size = host_cmd_pkg::NEG_SIZE_RESET;
      state_next.flush = 1'b1;
    end else begin
      // Command bits, reserved bits are not kept
      if (wr_cmd) begin
        state_next.size_read_request = host_wdata[host_cmd_pkg::CMD_SIZE_READ_BIT];
        state_next.size_write_request = host_wdata[host_cmd_pkg::CMD_SIZE_WRITE_BIT];
        state_next.host_control_flag = host_wdata[host_cmd_pkg::CMD_HOST_CTRL_BIT];
        // End of a host write releases the interface again
        if (state_reg.phase == host_cmd_pkg::PH_READY && state_reg.host_control_flag &&
            !host_wdata[host_cmd_pkg::CMD_HOST_CTRL_BIT]) begin
          state_next.free_to_accept_flag = 1'b1;
        end
      end
      // Count bytes, writable in either order
      if (wr_sel[host_cmd_pkg::OFS_COUNT_LOW]) begin
        state_next.byte_count[7:0] = host_wdata;
      end
      if (wr_sel[host_cmd_pkg::OFS_COUNT_HIGH]) begin
        state_next.byte_count[15:8] = host_wdata;
      end
      // First written byte marks the interface busy
      if (wr_byte) begin
        state_next.free_to_accept_flag = 1'b0;
      end
      // First read byte withdraws the pending flag
      if (rd_byte) begin
        state_next.outgoing_pending_flag = 1'b0;
      end
      unique case (state_reg.phase)
        host_cmd_pkg::PH_AWAIT_SIZE_READ: begin
          // Offer the buffer size as two bytes, high byte first
          if (state_reg.size_read_request) begin
            state_next.byte_count = host_cmd_pkg::SIZE_XFER_LEN;
            state_next.stage_byte = host_cmd_pkg::MODULE_BUF_SIZE[15:8];
            state_next.stage_full = 1'b1;
            state_next.size_byte_sel = 1'b0;
            state_next.outgoing_pending_flag = 1'b1;
            state_next.phase = host_cmd_pkg::PH_SIZE_READ;
          end
        end
        host_cmd_pkg::PH_SIZE_READ: begin
          if (rd_byte) begin
            if (!state_reg.size_byte_sel) begin
              state_next.stage_byte = host_cmd_pkg::MODULE_BUF_SIZE[7:0];
              state_next.size_byte_sel = 1'b1;
            end else begin
              state_next.stage_full = 1'b0;
              state_next.stage_byte = host_cmd_pkg::BYTE_RESET;
              state_next.size_byte_sel = 1'b0;
              state_next.phase = host_cmd_pkg::PH_AWAIT_SIZE_WRITE;
            end
          end
        end
        host_cmd_pkg::PH_AWAIT_SIZE_WRITE: begin
          // Chosen size arrives as two bytes, high byte first
          if (wr_byte) begin
            if (!state_reg.size_byte_sel) begin
              state_next.neg_size[15:8] = host_wdata;
              state_next.size_byte_sel = 1'b1;
            end else begin
              state_next.neg_size[7:0] = host_wdata;
              state_next.size_byte_sel = 1'b0;
              state_next.neg_done = 1'b1;
              state_next.free_to_accept_flag = 1'b1;
              state_next.phase = host_cmd_pkg::PH_READY;
            end
          end
        end
        host_cmd_pkg::PH_READY: begin
          // Host bytes pass straight to the module side
          if (wr_byte) begin
            state_next.rx_valid = 1'b1;
            state_next.rx_byte = host_wdata;
            state_next.rx_last = wr_last;
          end
          // Count is loaded in the same cycle as the pending flag rises
          if (tx_accept) begin
            state_next.byte_count = tx_count;
            state_next.outgoing_pending_flag = 1'b1;
            state_next.out_active = 1'b1;
          end
          // Outgoing transfer ends at its last counted byte
          if (rd_byte && rd_last) begin
            state_next.out_active = 1'b0;
          end
          // Data read consumes the staged byte
          if (rd_data) begin
            state_next.stage_full = 1'b0;
          end
          // Module side refills the staging byte
          if (tx_valid && state_reg.tx_ready) begin
            state_next.stage_byte = tx_data;
            state_next.stage_full = 1'b1;
          end
        end
      endcase
      // Staging byte free only once payload may flow
      state_next.tx_ready = (state_next.phase == host_cmd_pkg::PH_READY) &&
                            !state_next.stage_full;
    end
  end

  // Register the state; hardware reset ends with free raised
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg <= '0;
      state_reg.free_to_accept_flag <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Module side outputs
  assign rx_byte = state_reg.rx_byte;
  assign rx_valid = state_reg.rx_valid;
  assign rx_last = state_reg.rx_last;
  assign tx_ready = state_reg.tx_ready;
  assign iface_flush = state_reg.flush;
  assign size_negotiated = state_reg.neg_done;
  assign negotiated_size = state_reg.neg_size;

endmodule
`default_nettype wire

// ### verif/host_cmd_chk.sv
/*
  Concurrent checks on the host command interface ports.
  Assumes it is bound onto host_command_interface, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module host_cmd_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Host port
  input wire logic [1:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_rdata,
  input wire logic host_data_oe,
  // Module side
  input wire logic rx_valid,
  input wire logic rx_last,
  input wire logic tx_ready,
  input wire logic iface_flush,
  input wire logic size_negotiated
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Host writes the reset command bit
  sequence s_rst_cmd;
    host_wr && host_addr == 2'h1 && host_wdata[3];
  endsequence
  // One-cycle flush with negotiation lost
  sequence s_flush_done;
    iface_flush && !size_negotiated && !tx_ready ##1 !iface_flush && !tx_ready;
  endsequence
  a_flush_on_reset: assert property (s_rst_cmd |=> s_flush_done)
    else $error("reset command without flush");
  a_flush_cause: assert property (iface_flush |->
    $past(host_wr && host_addr == 2'h1 && host_wdata[3]))
    else $error("flush without reset command");
  a_oe_after_read: assert property (host_rd |=> host_data_oe)
    else $error("no read answer");
  a_oe_cause: assert property (host_data_oe |-> $past(host_rd))
    else $error("pins driven without read");
  a_reserved_zero: assert property (host_data_oe && $past(host_addr) == 2'h1 |->
    host_rdata[5:2] == 4'h0)
    else $error("reserved flag bits set");
  a_rx_cause: assert property (rx_valid |-> $past(host_wr && host_addr == 2'h0))
    else $error("payload byte without data write");
  a_rx_after_size: assert property (rx_valid |-> size_negotiated)
    else $error("payload before negotiation");
  a_last_valid: assert property (rx_last |-> rx_valid)
    else $error("last without byte");
  a_ready_after_size: assert property (tx_ready |-> size_negotiated)
    else $error("outgoing ready before negotiation");
  // Main scenario seen
  c_last_byte: cover property (rx_valid && rx_last);
endmodule
bind host_command_interface host_cmd_chk host_cmd_chk_inst (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .host_addr(host_addr), .host_wdata(host_wdata),
  .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata), .host_data_oe(host_data_oe),
  .rx_valid(rx_valid), .rx_last(rx_last), .tx_ready(tx_ready), .iface_flush(iface_flush),
  .size_negotiated(size_negotiated)
);
`default_nettype wire

// ### verif/host_model.sv
/*
  Host controller model: single register writes and reads.
  Assumes the interface strobes are one-cycle pulses on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic [1:0] host_addr,
  output logic [7:0] host_wdata,
  output logic host_wr,
  output logic host_rd,
  input wire logic [7:0] host_rdata
);
  // Idle bus at time zero
  initial begin
    host_addr = 2'h0;
    host_wdata = 8'h00;
    host_wr = 1'b0;
    host_rd = 1'b0;
  end
  // One write, strobe held over the taking edge
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #2;
    host_addr = a;
    host_wdata = (a == 2'h1) ? {4'h0, d[3:0]} : d;
    host_wr = 1'b1;
    @(posedge clk_sys);
    #2;
    host_wr = 1'b0;
    // Released bus must not keep the byte
    host_wdata = ~host_wdata;
  endtask
  // One read, byte taken the cycle after
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #2;
    host_addr = a;
    host_rd = 1'b1;
    @(posedge clk_sys);
    #2;
    host_rd = 1'b0;
    d = host_rdata;
  endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
/*
  Self-checking bench of the host command interface.
  Assumes host_model drives the register port; the bench drives the module side.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // Design signals
  logic clk_sys;
  logic sys_rst;
  logic [1:0] host_addr;
  logic [7:0] host_wdata;
  logic host_wr;
  logic host_rd;
  logic [7:0] host_rdata;
  logic host_data_oe;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic rx_last;
  logic tx_start;
  logic [15:0] tx_count;
  logic [7:0] tx_data;
  logic tx_valid;
  logic tx_ready;
  logic iface_flush;
  logic size_negotiated;
  logic [15:0] negotiated_size;
  // Bench state
  int error_cnt = 0;
  int n_tests = 0;
  int last_cnt = 0;
  int flush_cnt = 0;
  logic [7:0] rx_q[$];
  logic [7:0] v;

  host_command_interface host_command_interface_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata), .host_data_oe(host_data_oe),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_last(rx_last), .tx_start(tx_start),
    .tx_count(tx_count), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .iface_flush(iface_flush), .size_negotiated(size_negotiated),
    .negotiated_size(negotiated_size)
  );
  host_model host_model_inst (
    .clk_sys(clk_sys), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata)
  );

  // Clock, 25 ns period
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Collects payload bytes and flush pulses
  always @(posedge clk_sys) begin
    if (rx_valid === 1'b1) begin
      rx_q.push_back(rx_byte);
      if (rx_last === 1'b1) last_cnt++;
    end
    if (iface_flush === 1'b1) flush_cnt++;
  end

  // Verdict and end of run
  task automatic final_report();
    $display("Counts: %0d compared, %0d mismatched", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Value comparison
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Masked register read
  task automatic chk(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
    host_model_inst.rd(a, v);
    cmp({8'h00, v & m}, {8'h00, e}, "register byte");
    cmp({15'h0, host_data_oe}, 16'h0001, "read enable");
  endtask
  // Register write
  task automatic put(input logic [1:0] a, input logic [7:0] d);
    host_model_inst.wr(a, d);
  endtask
  // Module side announces an outgoing transfer
  task automatic announce(input logic [15:0] n);
    @(posedge clk_sys);
    #2;
    tx_start = 1'b1;
    tx_count = n;
    @(posedge clk_sys);
    #2;
    tx_start = 1'b0;
  endtask
  // Module side stages one byte, held until taken
  task automatic stage(input logic [7:0] b);
    int i;
    @(posedge clk_sys);
    #2;
    tx_data = b;
    tx_valid = 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (tx_ready === 1'b1) break;
    end
    cmp({15'h0, tx_ready}, 16'h0001, "staging taken");
    #2;
    tx_valid = 1'b0;
    tx_data = ~b;
  endtask

  // State after reset
  task automatic t_reset();
    chk(2'h1, 8'hFF, 8'h40);
    cmp({15'h0, tx_ready}, 16'h0000, "ready before size");
    $display("test reset done");
  endtask
  // Size read then size write of 256
  task automatic t_negotiate();
    put(2'h1, 8'h04);
    chk(2'h1, 8'h80, 8'h80);
    chk(2'h3, 8'hFF, 8'h00);
    chk(2'h2, 8'hFF, 8'h02);
    chk(2'h0, 8'hFF, host_cmd_pkg::MODULE_BUF_SIZE[15:8]);
    chk(2'h1, 8'h81, 8'h01);
    chk(2'h0, 8'hFF, host_cmd_pkg::MODULE_BUF_SIZE[7:0]);
    chk(2'h1, 8'h01, 8'h00);
    put(2'h1, 8'h00);
    put(2'h1, 8'h02);
    chk(2'h1, 8'h40, 8'h40);
    put(2'h2, 8'h02);
    put(2'h3, 8'h00);
    put(2'h0, 8'h01);
    chk(2'h1, 8'h42, 8'h02);
    put(2'h0, 8'h00);
    chk(2'h1, 8'h42, 8'h40);
    put(2'h1, 8'h00);
    cmp({15'h0, size_negotiated}, 16'h0001, "negotiated");
    cmp(negotiated_size, 16'h0100, "size");
    cmp({15'h0, tx_ready}, 16'h0001, "ready after size");
    $display("test negotiate done");
  endtask
  // Three-byte host write plus one extra byte
  task automatic t_host_write();
    rx_q.delete();
    chk(2'h1, 8'h80, 8'h00);
    put(2'h1, 8'h01);
    chk(2'h1, 8'h40, 8'h40);
    put(2'h3, 8'h00);
    put(2'h2, 8'h03);
    put(2'h0, 8'h11);
    chk(2'h1, 8'h42, 8'h02);
    put(2'h0, 8'h22);
    chk(2'h1, 8'h02, 8'h02);
    put(2'h0, 8'h33);
    chk(2'h1, 8'h42, 8'h00);
    put(2'h0, 8'h44);
    chk(2'h1, 8'h02, 8'h02);
    put(2'h1, 8'h00);
    chk(2'h1, 8'h40, 8'h40);
    for (int i = 0; i < 3; i++) begin
      cmp({8'h00, rx_q[i]}, {8'h00, 8'(8'h11 * (i + 1))}, "rx byte");
    end
    cmp(16'(last_cnt), 16'h0001, "last count");
    $display("test host write done");
  endtask
  // Refused and accepted outgoing transfers
  task automatic t_module_read();
    announce(16'h0101);
    chk(2'h1, 8'h80, 8'h00);
    announce(16'h0002);
    chk(2'h1, 8'h80, 8'h80);
    chk(2'h2, 8'hFF, 8'h02);
    chk(2'h3, 8'hFF, 8'h00);
    stage(8'hA5);
    chk(2'h0, 8'hFF, 8'hA5);
    chk(2'h1, 8'h81, 8'h01);
    stage(8'h5A);
    chk(2'h0, 8'hFF, 8'h5A);
    chk(2'h1, 8'h01, 8'h00);
    host_model_inst.rd(2'h0, v);
    chk(2'h1, 8'h01, 8'h01);
    $display("test module read done");
  endtask
  // Interface reset drops negotiation and refuses payload
  task automatic t_iface_reset();
    put(2'h1, 8'h0F);
    chk(2'h1, 8'hFF, 8'h40);
    cmp(16'(flush_cnt), 16'h0001, "flush");
    cmp({15'h0, size_negotiated}, 16'h0000, "negotiation lost");
    rx_q.delete();
    put(2'h1, 8'h01);
    put(2'h0, 8'h77);
    @(posedge clk_sys);
    #2;
    cmp(16'(rx_q.size()), 16'h0000, "payload refused");
    put(2'h1, 8'h00);
    $display("test interface reset done");
  endtask

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    tx_start = 1'b0;
    tx_count = 16'h0000;
    tx_data = 8'h00;
    tx_valid = 1'b0;
    repeat (12) @(posedge clk_sys);
    #2;
    sys_rst = 1'b0;
    t_reset();
    t_negotiate();
    t_host_write();
    t_module_read();
    t_iface_reset();
    final_report();
  end
  // Watchdog against a hang
  initial begin
    #(25 * 4000);
    error_cnt++;
    final_report();
  end
endmodule
`default_nettype wire
